/* shared/slt_pkg.sv */
`default_nettype none

package slt_pkg;

    // ------------------------------------------------------------
    // Register addressing
    // ------------------------------------------------------------
    localparam int SLT_ADDR_W = 12;
    localparam logic SLT_PAGE_DIGITAL = 1'b0;
    localparam logic SLT_PAGE_ANALOG = 1'b1;
    localparam int SLT_PAGE_BIT = 10;
    localparam logic [1:0] SLT_ALIGN_OK = 2'h0;

    localparam logic [7:0] SLT_IDX_LANE1_DEEMPH = 8'h12;
    localparam logic [7:0] SLT_IDX_LANE0_DEEMPH = 8'h13;
    localparam logic [7:0] SLT_IDX_LANE2_DEEMPH = 8'h14;
    localparam logic [7:0] SLT_IDX_LANE3_DEEMPH = 8'h15;
    localparam logic [7:0] SLT_IDX_ANALOG_RSVD = 8'h16;
    localparam logic [7:0] SLT_IDX_LANE_SHARING = 8'h16;
    localparam logic [7:0] SLT_IDX_TX_PLL_RESET = 8'h17;
    localparam logic [7:0] SLT_IDX_OVR_PIN_SEL = 8'h1a;
    localparam logic [7:0] SLT_IDX_SWING_OVR_EN = 8'h1b;
    localparam logic [7:0] SLT_IDX_CHAN_A_REORDER = 8'h31;
    localparam logic [7:0] SLT_IDX_CHAN_B_REORDER = 8'h32;
    localparam logic [7:0] SLT_IDX_STATUS = 8'h40;

    // ------------------------------------------------------------
    // Field layouts: writable field masks and mandated ones
    // ------------------------------------------------------------
    localparam logic [7:0] SLT_DEEMPH_FIELD = 8'hfc;
    localparam int SLT_DEEMPH_LSB = 2;
    localparam logic [7:0] SLT_LANE_SHARING_FIELD = 8'h10;
    localparam logic [7:0] SLT_LANE_SHARING_ONES = 8'h80;
    localparam int SLT_LANE_SHARE_BIT = 4;
    localparam logic [7:0] SLT_ANALOG_RSVD_FIELD = 8'h01;
    localparam logic [7:0] SLT_PLL_RESET_FIELD = 8'h40;
    localparam int SLT_PLL_RESET_BIT = 6;
    localparam logic [7:0] SLT_OVR_SEL_FIELD = 8'h02;
    localparam int SLT_OVR_SEL_BIT = 1;
    localparam logic [7:0] SLT_SWING_OVR_FIELD = 8'he8;
    localparam int SLT_SWING_LSB = 5;
    localparam int SLT_OVR_EN_BIT = 3;
    localparam logic [7:0] SLT_REORDER_FIELD = 8'hff;
    localparam logic [7:0] SLT_NO_ONES = 8'h00;

    localparam int SLT_ST_PLL_PULSED = 0;
    localparam int SLT_ST_SINGLE_LANE = 1;
    localparam int SLT_ST_PIN_OVERRIDDEN = 2;
    localparam int SLT_ST_RSVD_WRITE_ERR = 3;
    localparam int SLT_ST_DEEMPH_INVALID = 4;

    // ------------------------------------------------------------
    // Reset values and lookup tables
    // ------------------------------------------------------------
    localparam logic [7:0] SLT_REORDER_RESET = 8'h00;
    localparam logic [7:0] SLT_LANE_SHARING_RESET = 8'h80;
    localparam logic [31:0] SLT_RDATA_ZERO = 32'h0000_0000;
    localparam int SLT_LANES = 4;
    localparam int SLT_DEEMPH_W = 6;

    // Amplitude in mVpp for swing codes 7 down to 0.
    localparam logic [79:0] SLT_SWING_MVPP_TABLE = {
        10'h370, 10'h389, 10'h3a2, 10'h3c0,
        10'h2e9, 10'h302, 10'h32a, 10'h35c};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SLT_DECIM_NONE, SLT_DECIM_BY2, SLT_DECIM_BY4} slt_decim_t;

    typedef enum logic [1:0] {SLT_PLL_IDLE, SLT_PLL_RAISED, SLT_PLL_DONE} slt_pll_state_t;

    typedef struct packed {
        logic single_lane;
        logic map_active;
        logic [7:0] chan_a_stream_to_lane_map;
        logic [7:0] chan_b_stream_to_lane_map;
        logic [2:0] tx_output_amplitude_code;
        logic [9:0] tx_output_amplitude_mvpp;
        logic tx_pll_reset;
    } slt_tx_cfg_t;

    typedef struct packed {
        logic [SLT_LANES-1:0][SLT_DEEMPH_W-1:0] lane_deemphasis_code;
        logic [SLT_LANES-1:0][2:0] deemphasis_step;
        logic [SLT_LANES-1:0] code_valid;
    } slt_deemph_t;

endpackage

`default_nettype wire

/* rtl/slt_tx_config_regs.sv */
// Notes on behaviour
// - With lane sharing set and decimate-by-4 active both channels go out on one lane, otherwise one lane each.
// - Four lane registers hold a 6-bit thermometer de-emphasis code in bits 7-2, from 0 dB up to -11.5 dB.
// - The channel A over-range select bit routes the fast over-range flag to the power-down pin only with override enabled.
// - The override enable bit 3 lets the over-range flag take the power-down pin; clear keeps the normal function.
// - A 3-bit swing code in bits 7-5 sets one amplitude for all lanes, 745 to 960 mVpp by code.
`timescale 1ns/1ps
`default_nettype none

module slt_tx_config_regs
    import slt_pkg::*;
(
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SLT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device state
    input wire slt_decim_t decim_mode,
    input wire logic fast_overrange_flag,
    input wire logic power_down_pin,
    // Configuration to the transmit side
    output slt_tx_cfg_t tx_cfg,
    output slt_deemph_t deemph_cfg,
    output logic power_down_internal
);

    // ------------------------------------------------------------
    // Stored fields
    // ------------------------------------------------------------
    logic [SLT_LANES-1:0][SLT_DEEMPH_W-1:0] deemph_code;
    logic analog_rsvd_bit;
    logic lane_share;
    logic tx_pll_reset;
    logic chan_a_overrange_to_pin;
    logic pin_override_enable;
    logic [2:0] amplitude_code;
    logic [7:0] chan_a_map;
    logic [7:0] chan_b_map;
    logic rsvd_write_err;
    slt_pll_state_t pll_state;
    slt_pll_state_t next_pll_state;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic wr_access;
    logic page;
    logic [7:0] index;
    logic aligned;
    logic hit;
    logic [7:0] field_mask;
    logic [7:0] must_ones;
    logic [7:0] wbyte;
    logic rsvd_violation;
    logic [7:0] rd_byte;
    logic err_pending;

    assign setup_phase = psel && !penable;
    assign page = paddr[SLT_PAGE_BIT];
    assign index = paddr[9:2];
    assign aligned = (paddr[1:0] == SLT_ALIGN_OK);
    assign wbyte = pwdata[7:0];

    // Address map: field mask, mandated ones and read value per register.
    always_comb
    begin
        hit = 1'b1;
        field_mask = SLT_NO_ONES;
        must_ones = SLT_NO_ONES;
        rd_byte = SLT_NO_ONES;
        if (page == SLT_PAGE_ANALOG)
        begin
            case (index)
                SLT_IDX_LANE1_DEEMPH:
                begin
                    field_mask = SLT_DEEMPH_FIELD;
                    rd_byte = {deemph_code[1], 2'h0};
                end
                SLT_IDX_LANE0_DEEMPH:
                begin
                    field_mask = SLT_DEEMPH_FIELD;
                    rd_byte = {deemph_code[0], 2'h0};
                end
                SLT_IDX_LANE2_DEEMPH:
                begin
                    field_mask = SLT_DEEMPH_FIELD;
                    rd_byte = {deemph_code[2], 2'h0};
                end
                SLT_IDX_LANE3_DEEMPH:
                begin
                    field_mask = SLT_DEEMPH_FIELD;
                    rd_byte = {deemph_code[3], 2'h0};
                end
                SLT_IDX_ANALOG_RSVD:
                begin
                    field_mask = SLT_ANALOG_RSVD_FIELD;
                    rd_byte = {7'h00, analog_rsvd_bit};
                end
                SLT_IDX_TX_PLL_RESET:
                begin
                    field_mask = SLT_PLL_RESET_FIELD;
                    rd_byte = {1'b0, tx_pll_reset, 6'h00};
                end
                SLT_IDX_OVR_PIN_SEL:
                begin
                    field_mask = SLT_OVR_SEL_FIELD;
                    rd_byte = {6'h00, chan_a_overrange_to_pin, 1'b0};
                end
                SLT_IDX_SWING_OVR_EN:
                begin
                    field_mask = SLT_SWING_OVR_FIELD;
                    rd_byte = {amplitude_code, 1'b0, pin_override_enable, 3'h0};
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
        end
        else
        begin
            case (index)
                SLT_IDX_LANE_SHARING:
                begin
                    field_mask = SLT_LANE_SHARING_FIELD;
                    must_ones = SLT_LANE_SHARING_ONES;
                    rd_byte = {3'h4, lane_share, 4'h0};
                end
                SLT_IDX_CHAN_A_REORDER:
                begin
                    field_mask = SLT_REORDER_FIELD;
                    rd_byte = chan_a_map;
                end
                SLT_IDX_CHAN_B_REORDER:
                begin
                    field_mask = SLT_REORDER_FIELD;
                    rd_byte = chan_b_map;
                end
                SLT_IDX_STATUS:
                begin
                    field_mask = SLT_NO_ONES;
                    rd_byte = SLT_NO_ONES;
                    rd_byte[SLT_ST_PLL_PULSED] = (pll_state == SLT_PLL_DONE);
                    rd_byte[SLT_ST_SINGLE_LANE] = tx_cfg.single_lane;
                    rd_byte[SLT_ST_PIN_OVERRIDDEN] = chan_a_overrange_to_pin && pin_override_enable;
                    rd_byte[SLT_ST_RSVD_WRITE_ERR] = rsvd_write_err;
                    rd_byte[SLT_ST_DEEMPH_INVALID] = ~&deemph_cfg.code_valid;
                end
                default:
                begin
                    hit = 1'b0;
                end
            endcase
        end
        if (!aligned)
        begin
            hit = 1'b0;
        end
    end

    // A write that changes a reserved bit away from its mandated value is flagged.
    assign rsvd_violation = ((wbyte & ~field_mask) != must_ones) || (pwdata[31:8] != 24'h000000);
    assign wr_access = psel && penable && pwrite && hit && !err_pending;

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // Read data and the error answer are captured in the setup cycle, so every access finishes
    // in one access cycle with no wait state and prdata stays a flip-flop output.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= SLT_RDATA_ZERO;
            err_pending <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= (hit && !pwrite) ? {24'h000000, rd_byte} : SLT_RDATA_ZERO;
            err_pending <= !hit;
        end
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && err_pending;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    genvar gl;
    generate
        for (gl = 0; gl < SLT_LANES; gl++)
        begin : g_lane
            logic [7:0] lane_idx;
            logic [SLT_DEEMPH_W-1:0] code;
            logic [2:0] step;
            assign lane_idx = (gl == 0) ? SLT_IDX_LANE0_DEEMPH :
                              (gl == 1) ? SLT_IDX_LANE1_DEEMPH :
                              (gl == 2) ? SLT_IDX_LANE2_DEEMPH : SLT_IDX_LANE3_DEEMPH;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    deemph_code[gl] <= '0;
                end
                else if (wr_access && page == SLT_PAGE_ANALOG && index == lane_idx)
                begin
                    deemph_code[gl] <= wbyte[7:SLT_DEEMPH_LSB];
                end
            end
            // Thermometer code: the step is the count of ones; anything else is flagged invalid
            // and the step falls back to zero dB, the safe setting for the driver.
            assign code = deemph_code[gl];
            assign step = 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'(code[3]) + 3'(code[4]) + 3'(code[5]);
            assign deemph_cfg.lane_deemphasis_code[gl] = code;
            assign deemph_cfg.code_valid[gl] = ((code & (code + 6'h01)) == 6'h00);
            assign deemph_cfg.deemphasis_step[gl] = deemph_cfg.code_valid[gl] ? step : 3'h0;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog_rsvd_bit <= 1'b0;
            chan_a_overrange_to_pin <= 1'b0;
            amplitude_code <= 3'h0;
            pin_override_enable <= 1'b0;
        end
        else if (wr_access && page == SLT_PAGE_ANALOG)
        begin
            if (index == SLT_IDX_ANALOG_RSVD)
            begin
                analog_rsvd_bit <= wbyte[0];
            end
            if (index == SLT_IDX_OVR_PIN_SEL)
            begin
                chan_a_overrange_to_pin <= wbyte[SLT_OVR_SEL_BIT];
            end
            if (index == SLT_IDX_SWING_OVR_EN)
            begin
                amplitude_code <= wbyte[7:SLT_SWING_LSB];
                pin_override_enable <= wbyte[SLT_OVR_EN_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_pll_reset <= 1'b0;
        end
        else if (wr_access && page == SLT_PAGE_ANALOG && index == SLT_IDX_TX_PLL_RESET)
        begin
            tx_pll_reset <= wbyte[SLT_PLL_RESET_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane_share <= 1'b0;
            chan_a_map <= SLT_REORDER_RESET;
            chan_b_map <= SLT_REORDER_RESET;
        end
        else if (wr_access && page == SLT_PAGE_DIGITAL)
        begin
            if (index == SLT_IDX_LANE_SHARING)
            begin
                lane_share <= wbyte[SLT_LANE_SHARE_BIT];
            end
            if (index == SLT_IDX_CHAN_A_REORDER)
            begin
                chan_a_map <= wbyte;
            end
            if (index == SLT_IDX_CHAN_B_REORDER)
            begin
                chan_b_map <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Reserved-bit write error, write one to clear
    // ------------------------------------------------------------
    logic clr_rsvd_err;
    assign clr_rsvd_err = wr_access && page == SLT_PAGE_DIGITAL && index == SLT_IDX_STATUS
                          && wbyte[SLT_ST_RSVD_WRITE_ERR];

    // A fresh violation in the clearing cycle wins, so no error is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsvd_write_err <= 1'b0;
        end
        else if (wr_access && index != SLT_IDX_STATUS && rsvd_violation)
        begin
            rsvd_write_err <= 1'b1;
        end
        else if (clr_rsvd_err)
        begin
            rsvd_write_err <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // PLL reset pulse tracking
    // ------------------------------------------------------------
    // Tracks the 0 then 1 then 0 sequence so software can confirm the pulse was seen.
    always_comb
    begin
        next_pll_state = pll_state;
        if (wr_access && page == SLT_PAGE_ANALOG && index == SLT_IDX_TX_PLL_RESET)
        begin
            case (pll_state)
                SLT_PLL_IDLE:
                begin
                    if (wbyte[SLT_PLL_RESET_BIT])
                    begin
                        next_pll_state = SLT_PLL_RAISED;
                    end
                end
                SLT_PLL_RAISED:
                begin
                    if (!wbyte[SLT_PLL_RESET_BIT])
                    begin
                        next_pll_state = SLT_PLL_DONE;
                    end
                end
                SLT_PLL_DONE:
                begin
                    if (wbyte[SLT_PLL_RESET_BIT])
                    begin
                        next_pll_state = SLT_PLL_RAISED;
                    end
                end
                default:
                begin
                    next_pll_state = SLT_PLL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pll_state <= SLT_PLL_IDLE;
        end
        else
        begin
            pll_state <= next_pll_state;
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    // Lane sharing has no meaning outside decimate-by-4, so it is gated by the mode.
    assign tx_cfg.single_lane = lane_share && (decim_mode == SLT_DECIM_BY4);
    assign tx_cfg.map_active = (decim_mode == SLT_DECIM_BY2) || (decim_mode == SLT_DECIM_BY4);
    assign tx_cfg.chan_a_stream_to_lane_map = chan_a_map;
    assign tx_cfg.chan_b_stream_to_lane_map = chan_b_map;
    assign tx_cfg.tx_output_amplitude_code = amplitude_code;
    assign tx_cfg.tx_output_amplitude_mvpp = SLT_SWING_MVPP_TABLE[amplitude_code * 10 +: 10];
    assign tx_cfg.tx_pll_reset = tx_pll_reset;

    // The pin is taken over only when both the select and the enable are set.
    assign power_down_internal = (chan_a_overrange_to_pin && pin_override_enable)
                                 ? fast_overrange_flag : power_down_pin;

endmodule

`default_nettype wire

/* bench/slt_tx_config_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module slt_tx_config_regs_sva
    import slt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SLT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Device side
    input wire slt_decim_t decim_mode,
    input wire logic fast_overrange_flag,
    input wire logic power_down_pin,
    input wire slt_tx_cfg_t tx_cfg,
    input wire slt_deemph_t deemph_cfg,
    input wire logic power_down_internal
);
    // ------------------------------------------------------------
    // Shadow of the control bits
    // ------------------------------------------------------------
    localparam logic [9:0] MV [8] = '{10'h35c, 10'h32a, 10'h302, 10'h2e9, 10'h3c0, 10'h3a2, 10'h389, 10'h370};
    logic wr;
    logic share;
    logic sel;
    logic en;
    logic [2:0] sw;
    assign wr = psel && penable && pwrite && pready && paddr[1:0] == 2'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            share <= 1'b0;
            sel <= 1'b0;
            en <= 1'b0;
            sw <= 3'h0;
        end
        else if (wr)
        begin
            if (paddr == 12'h058) share <= pwdata[4];
            if (paddr == 12'h468) sel <= pwdata[1];
            if (paddr == 12'h46c) en <= pwdata[3];
            if (paddr == 12'h46c) sw <= pwdata[7:5];
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    ready_no_wait_a: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    pin_route_a: assert property (sel && en |-> power_down_internal == fast_overrange_flag)
        else $error("over-range flag not on pin");
    pin_normal_a: assert property (!(sel && en) |-> power_down_internal == power_down_pin)
        else $error("pin not in normal function");
    single_lane_a: assert property (tx_cfg.single_lane == (share && decim_mode == SLT_DECIM_BY4))
        else $error("lane sharing wrong");
    map_active_a: assert property (tx_cfg.map_active == (decim_mode inside {SLT_DECIM_BY2, SLT_DECIM_BY4}))
        else $error("map activity wrong");
    map_write_a: assert property (s_wr(12'h0c4) |=> tx_cfg.chan_a_stream_to_lane_map == $past(pwdata[7:0]))
        else $error("map A not updated");
    pll_write_a: assert property (s_wr(12'h45c) |=> tx_cfg.tx_pll_reset == $past(pwdata[6]))
        else $error("pll reset bit not updated");
    swing_code_a: assert property (tx_cfg.tx_output_amplitude_code == sw && tx_cfg.tx_output_amplitude_mvpp == MV[sw])
        else $error("swing amplitude wrong");
    for (genvar i = 0; i < SLT_LANES; i++)
    begin : g_lane
        deemph_code_a: assert property (deemph_cfg.code_valid[i] == (deemph_cfg.lane_deemphasis_code[i] inside
            {6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h1f, 6'h3f}) && deemph_cfg.deemphasis_step[i] ==
            (deemph_cfg.code_valid[i] ? 3'($countones(deemph_cfg.lane_deemphasis_code[i])) : 3'h0))
            else $error("deemphasis decode wrong");
    end
endmodule

bind slt_tx_config_regs slt_tx_config_regs_sva i_slt_tx_config_regs_sva (.*);

`default_nettype wire

/* bench/slt_tx_config_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module slt_tx_config_regs_tb;
    import slt_pkg::*;
    localparam logic [9:0] MV [8] = '{10'h35c, 10'h32a, 10'h302, 10'h2e9, 10'h3c0, 10'h3a2, 10'h389, 10'h370};
    localparam logic [11:0] LANE_A [4] = '{12'h44c, 12'h448, 12'h450, 12'h454};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    slt_decim_t decim_mode = SLT_DECIM_NONE;
    logic fast_overrange_flag = 1'b0;
    logic power_down_pin = 1'b0;
    slt_tx_cfg_t tx_cfg;
    slt_deemph_t deemph_cfg;
    logic power_down_internal;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] r;
    logic e;

    slt_tx_config_regs i_slt_tx_config_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .decim_mode(decim_mode), .fast_overrange_flag(fast_overrange_flag), .power_down_pin(power_down_pin),
        .tx_cfg(tx_cfg), .deemph_cfg(deemph_cfg), .power_down_internal(power_down_internal));

    // ------------------------------------------------------------
    // Clock, checks and bus tasks
    // ------------------------------------------------------------
    initial
    begin
        forever #10 pclk = ~pclk;
    end

    task complete_run;
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x);
        end
    endtask

    // The master waits for pready; only the watchdog bounds a stalled slave.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task drive(input slt_decim_t m, input logic f, input logic p);
        @(posedge pclk);
        decim_mode <= m;
        fast_overrange_flag <= f;
        power_down_pin <= p;
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        apb(0, 12'h0c4, 0);
        chk(r, 32'h0);
        apb(0, 12'h0c8, 0);
        chk(r, 32'h0);
        apb(0, 12'h058, 0);
        chk(r, 32'h80);
        for (int i = 0; i < 4; i++)
        begin
            apb(0, LANE_A[i], 0);
            chk(r, 32'h0);
        end
    endtask

    task t_share;
        apb(1, 12'h058, 32'h90);
        apb(0, 12'h058, 0);
        chk(r, 32'h90);
        drive(SLT_DECIM_BY4, 0, 0);
        chk(tx_cfg.single_lane, 1);
        apb(0, 12'h100, 0);
        chk(r[1], 1);
        drive(SLT_DECIM_BY2, 0, 0);
        chk(tx_cfg.single_lane, 0);
        chk(tx_cfg.map_active, 1);
        drive(SLT_DECIM_NONE, 0, 0);
        chk(tx_cfg.map_active, 0);
        apb(1, 12'h058, 32'h80);
        drive(SLT_DECIM_BY4, 0, 0);
        chk(tx_cfg.single_lane, 0);
    endtask

    task t_map;
        apb(1, 12'h0c4, 32'ha5);
        apb(1, 12'h0c8, 32'h3c);
        chk(tx_cfg.chan_a_stream_to_lane_map, 8'ha5);
        chk(tx_cfg.chan_b_stream_to_lane_map, 8'h3c);
        apb(0, 12'h0c8, 0);
        chk(r, 32'h3c);
    endtask

    task t_deemph;
        logic [5:0] c;
        for (int i = 0; i < 4; i++)
        begin
            for (int k = 0; k <= 6; k++)
            begin
                c = 6'((1 << k) - 1);
                apb(1, LANE_A[i], {24'h0, c, 2'h0});
                chk(deemph_cfg.lane_deemphasis_code[i], c);
                chk({deemph_cfg.code_valid[i], deemph_cfg.deemphasis_step[i]}, {1'b1, 3'(k)});
            end
            apb(1, LANE_A[i], 32'h08);
            chk({deemph_cfg.code_valid[i], deemph_cfg.deemphasis_step[i]}, 4'h0);
        end
        apb(0, 12'h100, 0);
        chk(r[4], 1);
    endtask

    task t_pll;
        apb(1, 12'h45c, 32'h00);
        chk(tx_cfg.tx_pll_reset, 0);
        apb(1, 12'h45c, 32'h40);
        chk(tx_cfg.tx_pll_reset, 1);
        apb(1, 12'h45c, 32'h00);
        chk(tx_cfg.tx_pll_reset, 0);
        apb(0, 12'h100, 0);
        chk(r[0], 1);
    endtask

    task t_swing;
        for (int k = 0; k < 8; k++)
        begin
            apb(1, 12'h46c, 32'(k << 5));
            chk(tx_cfg.tx_output_amplitude_mvpp, MV[k]);
        end
    endtask

    // Each select/enable pair is tried with flag and pin at opposite levels.
    task t_ovr;
        logic on;
        for (int k = 0; k < 4; k++)
        begin
            on = k == 3;
            apb(1, 12'h468, {30'h0, k[0], 1'b0});
            apb(1, 12'h46c, {28'h0, k[1], 3'h0});
            apb(0, 12'h100, 0);
            chk(r[2], on);
            drive(SLT_DECIM_NONE, 1, 0);
            chk(power_down_internal, on);
            drive(SLT_DECIM_NONE, 0, 1);
            chk(power_down_internal, !on);
        end
    endtask

    task t_bad;
        apb(0, 12'h3fc, 0);
        chk(e, 1);
        chk(r, 32'h0);
        apb(1, 12'h0c6, 32'hff);
        chk(e, 1);
        apb(0, 12'h0c4, 0);
        chk(r, 32'ha5);
        apb(1, 12'h058, 32'h10);
        apb(0, 12'h100, 0);
        chk(r[3], 1);
        apb(1, 12'h100, 32'h08);
        apb(0, 12'h100, 0);
        chk(r[3], 0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_share();
        t_map();
        t_deemph();
        t_pll();
        t_swing();
        t_ovr();
        t_bad();
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        complete_run();
    end
endmodule

`default_nettype wire
